// file: design/rss_datapath.sv
module rss_datapath #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // execution status
    output logic                   instr_done,
    output logic                   skip_taken
);
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("rss_datapath: ADDR_W must be at least 8");
    end

    typedef struct packed {
        rss_pkg::rss_state_t st;
        rss_pkg::rss_op_t    op;
        logic [2:0]          bsel;
        logic [7:0]          mem;
        logic [7:0]          imm;
        logic [7:0]          w;
        logic [3:0]          flags;
        logic                skip;
        logic                done;
        logic                ready;
        logic                slverr;
        logic [31:0]         rdata;
    } rss_regs_t;

    rss_regs_t r;
    rss_regs_t next_r;
    rss_alu_if alu_bus ();

    logic       access;
    logic       commit;
    logic       addr_hi_zero;
    logic [7:0] addr8;
    logic       hit;
    logic [31:0] rd_word;

    // operands always come from the live registers
    assign alu_bus.op   = r.op;
    assign alu_bus.mem  = r.mem;
    assign alu_bus.w    = r.w;
    assign alu_bus.imm  = r.imm;
    assign alu_bus.bsel = r.bsel;
    assign alu_bus.c_in = r.flags[rss_pkg::FLAG_C];

    rss_alu u_alu (
        .a (alu_bus.alu)
    );

    // address decode on the low byte, upper bits must be zero
    assign addr8        = paddr[7:0];
    assign addr_hi_zero = ((paddr >> 8) == '0);
    assign access       = psel & penable;
    assign commit       = access & r.ready;

    // read mux, unmapped addresses answer zero with an error
    always_comb begin
        hit     = addr_hi_zero;
        rd_word = 32'h0000_0000;
        case (addr8)
            rss_pkg::ADDR_CMD:   rd_word = {24'h00_0000, r.bsel, r.op};
            rss_pkg::ADDR_MEM:   rd_word = {24'h00_0000, r.mem};
            rss_pkg::ADDR_IMM:   rd_word = {24'h00_0000, r.imm};
            rss_pkg::ADDR_WREG:  rd_word = {24'h00_0000, r.w};
            rss_pkg::ADDR_FLAGS: rd_word = {28'h000_0000, r.flags};
            rss_pkg::ADDR_STAT: begin
                rd_word[rss_pkg::STAT_SKIP] = r.skip;
                rd_word[rss_pkg::STAT_BUSY] = (r.st != rss_pkg::ST_IDLE);
            end
            default: hit = 1'b0;
        endcase
        if (!hit) begin
            rd_word = 32'h0000_0000;
        end
    end

    // next state: bus slave plus the instruction sequencer
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        // the answer waits while an instruction runs, so no
        // register can change under the bus between answer and commit
        if (access && !r.ready && (r.st == rss_pkg::ST_IDLE)) begin
            next_r.ready  = 1'b1;
            next_r.slverr = ~hit;
            next_r.rdata  = pwrite ? 32'h0000_0000 : rd_word;
        end
        if (commit) begin
            next_r.ready = 1'b0;
        end
        // writes land only at the edge that samples pready high
        if (commit && pwrite && hit && pstrb[0]) begin
            case (addr8)
                rss_pkg::ADDR_CMD: begin
                    next_r.op   = rss_pkg::rss_op_t'(pwdata[rss_pkg::CMD_OP_LSB +: 5]);
                    next_r.bsel = pwdata[rss_pkg::CMD_BIT_LSB +: 3];
                    next_r.skip = 1'b0;
                    next_r.st   = rss_pkg::ST_EXEC;
                end
                rss_pkg::ADDR_MEM:   next_r.mem   = pwdata[7:0];
                rss_pkg::ADDR_IMM:   next_r.imm   = pwdata[7:0];
                rss_pkg::ADDR_WREG:  next_r.w     = pwdata[7:0];
                rss_pkg::ADDR_FLAGS: next_r.flags = pwdata[3:0];
                default: next_r.st = r.st;
            endcase
        end
        case (r.st)
            rss_pkg::ST_IDLE: begin
                next_r.st = next_r.st;
            end
            rss_pkg::ST_EXEC: begin
                if (alu_bus.to_w) begin
                    next_r.w = alu_bus.res;
                end
                if (alu_bus.to_mem) begin
                    next_r.mem = alu_bus.res;
                end
                // only flags the operation owns are touched
                next_r.flags = (r.flags & ~alu_bus.fl_we) |
                               (alu_bus.fl & alu_bus.fl_we);
                next_r.skip  = alu_bus.skip;
                if (alu_bus.two_cycle) begin
                    next_r.st = rss_pkg::ST_DUMMY;
                end else begin
                    next_r.st   = rss_pkg::ST_IDLE;
                    next_r.done = 1'b1;
                end
            end
            rss_pkg::ST_DUMMY: begin
                // dummy slot; no register changes, done is raised on the way back to idle
                next_r.st   = rss_pkg::ST_IDLE;
                next_r.done = 1'b1;
            end
            default: begin
                next_r.st = rss_pkg::ST_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r.st     <= rss_pkg::ST_IDLE;
            r.op     <= rss_pkg::OP_ROTL_THRU_FLAG_TO_W;
            r.bsel   <= 3'h0;
            r.mem    <= rss_pkg::RST_BYTE;
            r.imm    <= rss_pkg::RST_BYTE;
            r.w      <= rss_pkg::RST_BYTE;
            r.flags  <= rss_pkg::RST_FLAGS;
            r.skip   <= 1'b0;
            r.done   <= 1'b0;
            r.ready  <= 1'b0;
            r.slverr <= 1'b0;
            r.rdata  <= 32'h0000_0000;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign prdata     = r.rdata;
    assign pready     = r.ready;
    assign pslverr    = r.slverr;
    assign instr_done = r.done;
    assign skip_taken = r.skip;

    // snapshot of the operands for the checks below
    logic [7:0] h_mem;
    logic [7:0] h_w;
    logic [7:0] h_imm;
    logic [3:0] h_fl;
    logic       h_c;
    logic       exec;

    assign exec = (r.st == rss_pkg::ST_EXEC);

    always_ff @(posedge core_clk) begin
        h_mem <= r.mem;
        h_w   <= r.w;
        h_imm <= r.imm;
        h_fl  <= r.flags;
    end
    assign h_c = h_fl[rss_pkg::FLAG_C];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_rotl_carry_w: assert property (
        exec && r.op == rss_pkg::OP_ROTL_THRU_FLAG_TO_W |=>
        r.w == {h_mem[6:0], h_c} && r.flags[rss_pkg::FLAG_C] == h_mem[7] && r.mem == h_mem)
        else $error("left rotate through carry wrong");

    chk_rotr_mem_plain: assert property (
        exec && r.op == rss_pkg::OP_ROTR_MEM |=>
        r.mem == {h_mem[0], h_mem[7:1]} && r.flags == h_fl && r.w == h_w)
        else $error("memory right rotate wrong");

    chk_rotr_w_plain: assert property (
        exec && r.op == rss_pkg::OP_ROTR_TO_W |=>
        r.w == {h_mem[0], h_mem[7:1]} && r.mem == h_mem && r.flags == h_fl)
        else $error("right rotate into w wrong");

    chk_rotr_carry_mem: assert property (
        exec && r.op == rss_pkg::OP_ROTR_THRU_FLAG_MEM |=>
        r.mem == {h_c, h_mem[7:1]} && r.flags[rss_pkg::FLAG_C] == h_mem[0])
        else $error("right rotate through carry to memory wrong");

    chk_rotr_carry_w: assert property (
        exec && r.op == rss_pkg::OP_ROTR_THRU_FLAG_TO_W |=>
        r.w == {h_c, h_mem[7:1]} && r.mem == h_mem && r.flags[rss_pkg::FLAG_C] == h_mem[0])
        else $error("right rotate through carry into w wrong");

    chk_borrow_minus_w: assert property (
        exec && r.op == rss_pkg::OP_BORROW_MINUS_TO_W |=>
        r.w == 8'(h_w - h_mem - {7'h00, ~h_c}) &&
        r.flags[rss_pkg::FLAG_Z] == (r.w == 8'h00))
        else $error("borrow subtract result wrong");

    chk_minus_imm_w: assert property (
        exec && r.op == rss_pkg::OP_MINUS_IMM_TO_W |=>
        r.w == 8'(h_w - h_imm) && r.mem == h_mem)
        else $error("immediate subtract result wrong");

    chk_minus_carry_flag: assert property (
        exec && r.op == rss_pkg::OP_MINUS_TO_MEM |=>
        r.flags[rss_pkg::FLAG_C] == (h_w >= h_mem) && r.w == h_w)
        else $error("subtract carry wrong");

    chk_dec_skip_mem: assert property (
        exec && r.op == rss_pkg::OP_DEC_SKIP_NULL_MEM |=>
        r.mem == 8'(h_mem - 8'h01) && r.skip == (h_mem == 8'h01) && r.flags == h_fl)
        else $error("decrement skip wrong");

    chk_inc_skip_w: assert property (
        exec && r.op == rss_pkg::OP_INC_SKIP_NULL_TO_W |=>
        r.w == 8'(h_mem + 8'h01) && r.mem == h_mem && r.skip == (h_mem == 8'hff))
        else $error("increment skip into w wrong");

    chk_skip_two_cycle: assert property (
        exec && alu_bus.two_cycle |=>
        r.st == rss_pkg::ST_DUMMY && !r.done ##1 r.st == rss_pkg::ST_IDLE && r.done)
        else $error("skip instruction not two cycles");

    chk_fill_byte: assert property (
        exec && r.op == rss_pkg::OP_FILL_ONES_BYTE |=> r.mem == 8'hff && r.flags == h_fl)
        else $error("byte fill wrong");

    chk_bit_zero_skip: assert property (
        exec && r.op == rss_pkg::OP_TEST_NULL_SKIP_BIT |=>
        r.skip == ~h_mem[r.bsel] && r.mem == h_mem && r.w == h_w)
        else $error("bit zero skip wrong");

    chk_nibble_w: assert property (
        exec && r.op == rss_pkg::OP_NIBBLE_EXCHANGE_TO_W |=>
        r.w == {h_mem[3:0], h_mem[7:4]} && r.mem == h_mem)
        else $error("nibble swap into w wrong");

    // remaining skip, fill and swap forms, checked one cycle after exec
    chk_dec_skip_w: assert property (
        exec && r.op == rss_pkg::OP_DEC_SKIP_NULL_TO_W |=>
        r.w == 8'(h_mem - 8'h01) && r.mem == h_mem &&
        r.skip == (h_mem == 8'h01) && r.flags == h_fl)
        else $error("decrement skip into w wrong");

    chk_inc_skip_mem: assert property (
        exec && r.op == rss_pkg::OP_INC_SKIP_NULL_MEM |=>
        r.mem == 8'(h_mem + 8'h01) && r.skip == (h_mem == 8'hff) && r.flags == h_fl)
        else $error("increment skip in memory wrong");

    chk_fill_bit: assert property (
        exec && r.op == rss_pkg::OP_FILL_ONES_BIT |=>
        r.mem == (h_mem | (8'h01 << r.bsel)) && r.flags == h_fl)
        else $error("bit fill wrong");

    chk_bit_one_skip: assert property (
        exec && r.op == rss_pkg::OP_SKIP_BIT_ONE |=>
        r.skip == h_mem[r.bsel] && r.mem == h_mem && r.flags == h_fl)
        else $error("bit one skip wrong");

    chk_byte_zero_skip: assert property (
        exec && r.op == rss_pkg::OP_TEST_NULL_SKIP_BYTE |=>
        r.skip == (h_mem == 8'h00) && r.mem == h_mem && r.w == h_w)
        else $error("byte zero skip wrong");

    chk_copy_zero_skip: assert property (
        exec && r.op == rss_pkg::OP_COPY_TEST_NULL_SKIP |=>
        r.w == h_mem && r.skip == (h_mem == 8'h00) && r.flags == h_fl)
        else $error("copy zero skip wrong");

    chk_nibble_mem: assert property (
        exec && r.op == rss_pkg::OP_NIBBLE_EXCHANGE_MEM |=>
        r.mem == {h_mem[3:0], h_mem[7:4]} && r.flags == h_fl)
        else $error("nibble swap in memory wrong");

    chk_apb_answer: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    cov_skip_taken: cover property (
        exec && alu_bus.two_cycle && alu_bus.skip ##2 r.done);
    cov_subtract_neg: cover property (
        exec && r.op == rss_pkg::OP_MINUS_TO_W ##1 !r.flags[rss_pkg::FLAG_C]);
    cov_cmd_write: cover property (
        commit && pwrite && addr8 == rss_pkg::ADDR_CMD);
    cov_unmapped: cover property (pready && pslverr);
    cov_bit_fill: cover property (exec && r.op == rss_pkg::OP_FILL_ONES_BIT);
endmodule

// file: include/rss_pkg.sv
package rss_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] ADDR_CMD   = 8'h00;
    localparam logic [7:0] ADDR_MEM   = 8'h04;
    localparam logic [7:0] ADDR_IMM   = 8'h08;
    localparam logic [7:0] ADDR_WREG  = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;
    // command word: opcode in [4:0], bit index in [7:5]
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_BIT_LSB = 5;
    // flag positions in the status byte
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam logic [3:0] FLAG_MASK_C   = 4'h1;
    localparam logic [3:0] FLAG_MASK_ALL = 4'hf;
    // status word bits
    localparam int STAT_SKIP = 0;
    localparam int STAT_BUSY = 1;
    // reset and fill values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ONE  = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [4:0] {
        OP_ROTL_THRU_FLAG_TO_W = 5'h00,
        OP_ROTR_MEM            = 5'h01,
        OP_ROTR_TO_W           = 5'h02,
        OP_ROTR_THRU_FLAG_MEM  = 5'h03,
        OP_ROTR_THRU_FLAG_TO_W = 5'h04,
        OP_BORROW_MINUS_TO_W   = 5'h05,
        OP_BORROW_MINUS_TO_MEM = 5'h06,
        OP_MINUS_TO_W          = 5'h07,
        OP_MINUS_TO_MEM        = 5'h08,
        OP_MINUS_IMM_TO_W      = 5'h09,
        OP_DEC_SKIP_NULL_MEM   = 5'h0a,
        OP_DEC_SKIP_NULL_TO_W  = 5'h0b,
        OP_INC_SKIP_NULL_MEM   = 5'h0c,
        OP_INC_SKIP_NULL_TO_W  = 5'h0d,
        OP_FILL_ONES_BYTE      = 5'h0e,
        OP_FILL_ONES_BIT       = 5'h0f,
        OP_SKIP_BIT_ONE        = 5'h10,
        OP_TEST_NULL_SKIP_BYTE = 5'h11,
        OP_COPY_TEST_NULL_SKIP = 5'h12,
        OP_TEST_NULL_SKIP_BIT  = 5'h13,
        OP_NIBBLE_EXCHANGE_MEM = 5'h14,
        OP_NIBBLE_EXCHANGE_TO_W = 5'h15
    } rss_op_t;

    // gray codes along idle, exec, dummy
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_DUMMY = 2'b11
    } rss_state_t;
endpackage

// file: include/rss_alu_if.sv
interface rss_alu_if;
    rss_pkg::rss_op_t op;
    logic [7:0]       mem;
    logic [7:0]       w;
    logic [7:0]       imm;
    logic [2:0]       bsel;
    logic             c_in;
    logic [7:0]       res;
    logic             to_w;
    logic             to_mem;
    logic [3:0]       fl;
    logic [3:0]       fl_we;
    logic             two_cycle;
    logic             skip;

    modport alu  (input op, mem, w, imm, bsel, c_in,
                  output res, to_w, to_mem, fl, fl_we, two_cycle, skip);
    modport core (output op, mem, w, imm, bsel, c_in,
                  input res, to_w, to_mem, fl, fl_we, two_cycle, skip);
endinterface

// file: design/rss_alu.sv
module rss_alu (
    // operands in, results out
    rss_alu_if.alu a
);
    logic [7:0] sub_b;
    logic       borrow_in;
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] inc;
    logic [7:0] dec;

    // one datapath pass, no state of its own
    always_comb begin
        a.res       = a.mem;
        a.to_w      = 1'b0;
        a.to_mem    = 1'b0;
        a.fl        = rss_pkg::RST_FLAGS;
        a.fl_we     = rss_pkg::RST_FLAGS;
        a.two_cycle = 1'b0;
        a.skip      = 1'b0;
        sub_b       = (a.op == rss_pkg::OP_MINUS_IMM_TO_W) ? a.imm : a.mem;
        // borrow forms take the inverse of the carry as extra borrow
        borrow_in   = ((a.op == rss_pkg::OP_BORROW_MINUS_TO_W) ||
                       (a.op == rss_pkg::OP_BORROW_MINUS_TO_MEM)) ? ~a.c_in : 1'b0;
        diff        = {1'b0, a.w} - {1'b0, sub_b} - {8'h00, borrow_in};
        ldiff       = {1'b0, a.w[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow_in};
        inc         = a.mem + rss_pkg::BYTE_ONE;
        dec         = a.mem - rss_pkg::BYTE_ONE;
        case (a.op)
            rss_pkg::OP_ROTL_THRU_FLAG_TO_W: begin
                a.res                = {a.mem[6:0], a.c_in};
                a.to_w               = 1'b1;
                a.fl[rss_pkg::FLAG_C] = a.mem[7];
                a.fl_we              = rss_pkg::FLAG_MASK_C;
            end
            rss_pkg::OP_ROTR_MEM: begin
                a.res    = {a.mem[0], a.mem[7:1]};
                a.to_mem = 1'b1;
            end
            rss_pkg::OP_ROTR_TO_W: begin
                a.res  = {a.mem[0], a.mem[7:1]};
                a.to_w = 1'b1;
            end
            rss_pkg::OP_ROTR_THRU_FLAG_MEM, rss_pkg::OP_ROTR_THRU_FLAG_TO_W: begin
                a.res                = {a.c_in, a.mem[7:1]};
                a.to_mem             = (a.op == rss_pkg::OP_ROTR_THRU_FLAG_MEM);
                a.to_w               = (a.op == rss_pkg::OP_ROTR_THRU_FLAG_TO_W);
                a.fl[rss_pkg::FLAG_C] = a.mem[0];
                a.fl_we              = rss_pkg::FLAG_MASK_C;
            end
            rss_pkg::OP_BORROW_MINUS_TO_W, rss_pkg::OP_BORROW_MINUS_TO_MEM,
            rss_pkg::OP_MINUS_TO_W, rss_pkg::OP_MINUS_TO_MEM,
            rss_pkg::OP_MINUS_IMM_TO_W: begin
                a.res     = diff[7:0];
                a.to_mem  = (a.op == rss_pkg::OP_BORROW_MINUS_TO_MEM) ||
                            (a.op == rss_pkg::OP_MINUS_TO_MEM);
                a.to_w    = ~a.to_mem;
                a.fl[rss_pkg::FLAG_C]  = ~diff[8];
                a.fl[rss_pkg::FLAG_AC] = ~ldiff[4];
                a.fl[rss_pkg::FLAG_Z]  = (diff[7:0] == rss_pkg::BYTE_ZERO);
                a.fl[rss_pkg::FLAG_OV] = (a.w[7] ^ sub_b[7]) & (a.w[7] ^ diff[7]);
                a.fl_we   = rss_pkg::FLAG_MASK_ALL;
            end
            rss_pkg::OP_DEC_SKIP_NULL_MEM, rss_pkg::OP_DEC_SKIP_NULL_TO_W: begin
                a.res       = dec;
                a.to_mem    = (a.op == rss_pkg::OP_DEC_SKIP_NULL_MEM);
                a.to_w      = ~a.to_mem;
                a.skip      = (dec == rss_pkg::BYTE_ZERO);
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_INC_SKIP_NULL_MEM, rss_pkg::OP_INC_SKIP_NULL_TO_W: begin
                a.res       = inc;
                a.to_mem    = (a.op == rss_pkg::OP_INC_SKIP_NULL_MEM);
                a.to_w      = ~a.to_mem;
                a.skip      = (inc == rss_pkg::BYTE_ZERO);
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_FILL_ONES_BYTE: begin
                a.res    = rss_pkg::BYTE_ONES;
                a.to_mem = 1'b1;
            end
            rss_pkg::OP_FILL_ONES_BIT: begin
                a.res         = a.mem;
                a.res[a.bsel] = 1'b1;
                a.to_mem      = 1'b1;
            end
            rss_pkg::OP_SKIP_BIT_ONE: begin
                a.skip      = a.mem[a.bsel];
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_TEST_NULL_SKIP_BYTE: begin
                a.skip      = (a.mem == rss_pkg::BYTE_ZERO);
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_COPY_TEST_NULL_SKIP: begin
                a.to_w      = 1'b1;
                a.skip      = (a.mem == rss_pkg::BYTE_ZERO);
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_TEST_NULL_SKIP_BIT: begin
                a.skip      = ~a.mem[a.bsel];
                a.two_cycle = 1'b1;
            end
            rss_pkg::OP_NIBBLE_EXCHANGE_MEM, rss_pkg::OP_NIBBLE_EXCHANGE_TO_W: begin
                a.res    = {a.mem[3:0], a.mem[7:4]};
                a.to_mem = (a.op == rss_pkg::OP_NIBBLE_EXCHANGE_MEM);
                a.to_w   = ~a.to_mem;
            end
            // unknown codes retire as a one-cycle no-op
            default: begin
                a.res = a.mem;
            end
        endcase
    end
endmodule

// file: verification/tb_rss_datapath.sv
module tb_rss_datapath;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 20000;

    logic        core_clk, rst_n, psel, penable, pwrite;
    logic        pready, pslverr, instr_done, skip_taken;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          fail_count, tests_run, cyc, done_at, ack_at, seed;

    rss_datapath dut (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_done(instr_done), .skip_taken(skip_taken)
    );

    // free-running clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // cycle count, retire stamp and hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (instr_done === 1'b1) done_at <= cyc;
        if (cyc == LIMIT) begin
            fail_count++;
            $display("BAD timeout expected %0d seen %0d", LIMIT - 1, cyc);
            final_report();
        end
    end

    task automatic final_report();
        $display("counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // one apb transfer; entered just after a rising edge, leaves one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        ack_at = cyc;
        chk_cnt("pready_wait", 2, n);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // write a byte with junk in the unused upper bits
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] d, rd;
        logic        er;
        d = $random(seed);
        d[7:0] = v;
        apb(1'b1, a, d, 4'hf, rd, er);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, 4'hf, rd, er);
        chk(nm, e, rd);
    endtask

    // subtract with borrow-in, flags in status order c, ac, z, ov
    function automatic void sub(input logic [7:0] a, input logic [7:0] s, input logic bi,
                                output logic [7:0] r, inout logic [3:0] f);
        logic [8:0] d;
        logic [4:0] h;
        d = {1'b0, a} - {1'b0, s} - {8'h00, bi};
        h = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, bi};
        r = d[7:0];
        f[0] = ~d[8];
        f[1] = ~h[4];
        f[2] = (r == 8'h00);
        f[3] = (a[7] != s[7]) && (r[7] != a[7]);
    endfunction

    function automatic void predict(input logic [4:0] op, input logic [2:0] b,
                                    input logic [7:0] m, w, imm, input logic [3:0] fi,
                                    output logic [7:0] em, ew, output logic [3:0] ef,
                                    output logic es, et);
        em = m; ew = w; ef = fi; es = 1'b0;
        case (op)
            5'h00: begin ew = {m[6:0], fi[0]}; ef[0] = m[7]; end
            5'h01: em = {m[0], m[7:1]};
            5'h02: ew = {m[0], m[7:1]};
            5'h03: begin em = {fi[0], m[7:1]}; ef[0] = m[0]; end
            5'h04: begin ew = {fi[0], m[7:1]}; ef[0] = m[0]; end
            5'h05: sub(w, m, ~fi[0], ew, ef);
            5'h06: sub(w, m, ~fi[0], em, ef);
            5'h07: sub(w, m, 1'b0, ew, ef);
            5'h08: sub(w, m, 1'b0, em, ef);
            5'h09: sub(w, imm, 1'b0, ew, ef);
            5'h0a: begin em = m - 8'h01; es = (em == 8'h00); end
            5'h0b: begin ew = m - 8'h01; es = (ew == 8'h00); end
            5'h0c: begin em = m + 8'h01; es = (em == 8'h00); end
            5'h0d: begin ew = m + 8'h01; es = (ew == 8'h00); end
            5'h0e: em = 8'hff;
            5'h0f: em[b] = 1'b1;
            5'h10: es = m[b];
            5'h11: es = (m == 8'h00);
            5'h12: begin ew = m; es = (m == 8'h00); end
            5'h13: es = ~m[b];
            5'h14: em = {m[3:0], m[7:4]};
            5'h15: ew = {m[3:0], m[7:4]};
            default: ;
        endcase
        et = (op inside {[5'h0a:5'h0d], [5'h10:5'h13]});
    endfunction

    // load operands, run one instruction, check every visible result
    task automatic run_op(input logic [4:0] op, input int k);
        logic [7:0] m, w, imm, em, ew;
        logic [3:0] fl, ef;
        logic [2:0] b;
        logic       es, et;
        int         n;
        m = 8'($random(seed)); w = 8'($random(seed)); imm = 8'($random(seed));
        fl = 4'($random(seed)); b = 3'($random(seed)); n = 0;
        if (k == 0) m = 8'h00;
        if (k == 1) begin m = 8'hff; w = 8'h00; end
        if (k == 2) begin m = 8'h01; w = 8'h01; imm = 8'h01; end
        if (k == 3) begin m = 8'h80; w = 8'h7f; imm = 8'h80; end
        predict(op, b, m, w, imm, fl, em, ew, ef, es, et);
        wr(rss_pkg::ADDR_MEM, m);
        wr(rss_pkg::ADDR_WREG, w);
        wr(rss_pkg::ADDR_IMM, imm);
        wr(rss_pkg::ADDR_FLAGS, {4'h0, fl});
        wr(rss_pkg::ADDR_CMD, {b, op});
        while (done_at <= ack_at && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chk_cnt("retire_cycles", et ? 3 : 2, done_at - ack_at);
        chk("skip_taken", {31'h0, es}, {31'h0, skip_taken});
        rdchk("stat", rss_pkg::ADDR_STAT, {31'h0, es});
        rdchk("mem", rss_pkg::ADDR_MEM, {24'h0, em});
        rdchk("wreg", rss_pkg::ADDR_WREG, {24'h0, ew});
        rdchk("flags", rss_pkg::ADDR_FLAGS, {28'h0, ef});
        $display("test op %h case %0d done", op, k);
    endtask

    initial begin
        logic [31:0] rd;
        logic        er;
        seed = 32'h3302;
        cyc = 0; done_at = 0; ack_at = 0; fail_count = 0; tests_run = 0;
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; pstrb = 4'h0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        // every register clears on reset
        for (int i = 0; i < 6; i++) rdchk("reset_value", 8'(i * 4), 32'h0000_0000);
        $display("test reset values done");
        // unmapped place answers with an error and no data
        apb(1'b0, 8'h18, 32'h0000_0000, 4'hf, rd, er);
        chk("unmapped_rd_err", 32'h1, {31'h0, er});
        chk("unmapped_rd_data", 32'h0, rd);
        apb(1'b1, 8'h20, 32'hffff_ffff, 4'hf, rd, er);
        chk("unmapped_wr_err", 32'h1, {31'h0, er});
        // write with the low strobe off is dropped
        apb(1'b1, rss_pkg::ADDR_MEM, 32'h0000_005a, 4'he, rd, er);
        rdchk("strobe_off_mem", rss_pkg::ADDR_MEM, 32'h0000_0000);
        $display("test bus errors done");
        // every opcode plus two spare codes, corner cases then random
        for (int op = 0; op < 24; op++) begin
            for (int k = 0; k < 6; k++) begin
                run_op(op == 22 ? 5'h16 : op == 23 ? 5'h1f : 5'(op), k);
            end
        end
        final_report();
    end
endmodule
